// file: src/pcd_pkg.sv
// Package for the pulse count input decoder: modes, widths and reset values.
// Assumes a single system clock domain and no register bus.
package pcd_pkg;
   // ==========================================================================
   // Count input modes
   typedef enum logic [3:0] {
      single_edge_with_user_b,
      double_edge_with_user_b,
      single_edge_direction_ctl,
      double_edge_direction_ctl,
      add_subtract,
      add_add,
      quad_x1,
      quad_x2,
      quad_x4
   } count_mode_t;
   // ==========================================================================
   // Fixed point layout: factor in units of 0.00001.
   localparam int FACTOR_W = 20;
   localparam logic [19:0] FACTOR_MIN = 20'h0_0001;
   localparam logic [19:0] FACTOR_MAX = 20'hF_423F;
   localparam logic [19:0] FACTOR_UNITY = 20'h1_86A0;
   localparam logic [19:0] FACTOR_RESET = 20'h1_86A0;
   localparam int COUNT_W = 48;
   localparam logic [47:0] COUNT_RESET = 48'h0000_0000_0000;
   localparam logic [2:0] FRACTION_MAX = 3'h5;
   localparam logic [2:0] FRACTION_RESET = 3'h0;
endpackage

// file: src/pcd_sync.sv
// Two flip-flop synchroniser with an edge detector on the stable stage.
// Assumes the input is asynchronous to CLK_SYS.
`timescale 1ns/1ps
module pcd_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic din,
   output logic level,
   output logic rise,
   output logic fall
);
   // ==========================================================================
   // State
   typedef struct packed {
      logic meta;
      logic stab;
      logic prev;
      logic [1:0] fill;
   } sync_t;
   sync_t s_r;
   sync_t s_nxt;
   always_comb begin
      s_nxt = s_r;
      s_nxt.meta = din;
      s_nxt.stab = s_r.meta;
      s_nxt.prev = s_r.stab;
      s_nxt.fill = {s_r.fill[0], 1'b1};
      // Until two real samples have passed, prev follows stab, so the
      // reset level of the flops never shows up as a false edge.
      if (!s_r.fill[1]) begin
         s_nxt.prev = s_nxt.stab;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   // Edges compare the current and previous synchronised samples.
   assign level = s_r.stab;
   assign rise = s_r.stab & ~s_r.prev;
   assign fall = ~s_r.stab & s_r.prev;
endmodule // pcd_sync

// file: src/pulse_count_input_decoder.sv
// Count front end: decodes inputs A and B into scaled signed count steps.
// Assumes the pulse sources are asynchronous and settings are static levels.
//
// Summary of operation
// - Each event adds the scaling factor, or subtracts it on down counts.
// - A factor of one moves the count by exactly one unit per event.
// - Factor limited to one on scaled-output or batch totalizing builds.
// - Fraction position selects zero to five displayed decimal digits.
// - Nine count modes; A-only modes free input B as user input.
// - Single-edge user mode counts falling A edges; B goes to user.
// - Double-edge modes count both edges of input A.
// - Direction modes: B high counts up, B low counts down.
// - Add/subtract: A falls add, B falls subtract, coincident both kept.
// - Add/add: falling edges on A and B both add, coincident both kept.
// - Quad x1 with B low: A falls count up, A rises count down.
// - Quad x1 ignores all A transitions while B is high.
// - Quad x2 with B high: A rises count up, A falls count down.
// - Quad x4 counts every edge of A and B with swapped roles.
`timescale 1ns/1ps
module pulse_count_input_decoder (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic IN_A,
   input wire logic IN_B,
   input wire logic [3:0] COUNT_MODE,
   input wire logic [19:0] SCALE_FACTOR,
   input wire logic SCALED_OUTPUT_BUILD,
   input wire logic BATCH_TOTALIZING,
   input wire logic [2:0] DISPLAY_FRACTION_POSITION,
   input wire logic COUNT_CLEAR,
   output logic signed [47:0] COUNT_VALUE,
   output logic [2:0] FRACTION_DIGITS,
   output logic [19:0] FACTOR_IN_USE,
   output logic SECOND_INPUT_USER_FUNCTION,
   output logic USER_B_VALID,
   output logic COUNT_STEP
);
   // ==========================================================================
   // Synchronisers
   logic a_lvl, a_rise, a_fall, b_lvl, b_rise, b_fall;
   pcd_sync u_sync_a (
      .clk(CLK_SYS), .rst_n(RST_N), .din(IN_A),
      .level(a_lvl), .rise(a_rise), .fall(a_fall)
   );
   pcd_sync u_sync_b (
      .clk(CLK_SYS), .rst_n(RST_N), .din(IN_B),
      .level(b_lvl), .rise(b_rise), .fall(b_fall)
   );
   // ==========================================================================
   // State
   typedef struct packed {
      logic signed [47:0] count;
      logic pend_down;
      logic step;
      logic user_b;
      logic [2:0] frac;
      logic [19:0] factor;
   } core_t;
   core_t c_r;
   core_t c_nxt;
   pcd_pkg::count_mode_t mode;
   logic ev_up, ev_dn, user_mode, lim_one;
   logic [19:0] fac;
   logic signed [47:0] fac_ext;
   assign mode = pcd_pkg::count_mode_t'(COUNT_MODE);
   assign user_mode = (mode == pcd_pkg::single_edge_with_user_b) ||
                      (mode == pcd_pkg::double_edge_with_user_b);
   assign lim_one = SCALED_OUTPUT_BUILD | BATCH_TOTALIZING;
   // ==========================================================================
   // Event decode; B quarter-period displacement is assumed for quadrature.
   always_comb begin
      ev_up = 1'b0;
      ev_dn = 1'b0;
      case (mode)
         pcd_pkg::single_edge_with_user_b: begin
            ev_up = a_fall;
         end
         pcd_pkg::double_edge_with_user_b: begin
            ev_up = a_fall | a_rise;
         end
         pcd_pkg::single_edge_direction_ctl: begin
            ev_up = a_fall & b_lvl;
            ev_dn = a_fall & ~b_lvl;
         end
         pcd_pkg::double_edge_direction_ctl: begin
            ev_up = (a_fall | a_rise) & b_lvl;
            ev_dn = (a_fall | a_rise) & ~b_lvl;
         end
         pcd_pkg::add_subtract: begin
            ev_up = a_fall;
            ev_dn = b_fall;
         end
         pcd_pkg::add_add: begin
            ev_up = a_fall;
            ev_dn = b_fall;
         end
         pcd_pkg::quad_x1: begin
            ev_up = a_fall & ~b_lvl;
            ev_dn = a_rise & ~b_lvl;
         end
         pcd_pkg::quad_x2: begin
            ev_up = (a_fall & ~b_lvl) | (a_rise & b_lvl);
            ev_dn = (a_rise & ~b_lvl) | (a_fall & b_lvl);
         end
         pcd_pkg::quad_x4: begin
            ev_up = (a_fall & ~b_lvl) | (a_rise & b_lvl) |
                    (b_fall & a_lvl) | (b_rise & ~a_lvl);
            ev_dn = (a_rise & ~b_lvl) | (a_fall & b_lvl) |
                    (b_rise & a_lvl) | (b_fall & ~a_lvl);
         end
         default: begin
            ev_up = 1'b0;
            ev_dn = 1'b0;
         end
      endcase
   end
   // ==========================================================================
   // Factor clamping; an out-of-range factor is pinned rather than refused.
   always_comb begin
      fac = SCALE_FACTOR;
      if (fac < pcd_pkg::FACTOR_MIN) begin
         fac = pcd_pkg::FACTOR_MIN;
      end
      if (fac > pcd_pkg::FACTOR_MAX) begin
         fac = pcd_pkg::FACTOR_MAX;
      end
      if (lim_one && fac > pcd_pkg::FACTOR_UNITY) begin
         fac = pcd_pkg::FACTOR_UNITY;
      end
   end
   assign fac_ext = $signed({28'h000_0000, c_r.factor});
   // ==========================================================================
   // Accumulator. Coincident events are split over two cycles: one applied
   // now, the second parked in pend_down. In add/add the parked one adds.
   always_comb begin
      logic up_now, dn_now, add_add_mode;
      up_now = 1'b0;
      dn_now = 1'b0;
      add_add_mode = (mode == pcd_pkg::add_add);
      c_nxt = c_r;
      c_nxt.factor = fac;
      c_nxt.frac = DISPLAY_FRACTION_POSITION;
      if (DISPLAY_FRACTION_POSITION > pcd_pkg::FRACTION_MAX) begin
         c_nxt.frac = pcd_pkg::FRACTION_MAX;
      end
      c_nxt.user_b = b_lvl;
      c_nxt.pend_down = 1'b0;
      if (c_r.pend_down) begin
         dn_now = 1'b1;
      end else begin
         up_now = ev_up;
         dn_now = ev_dn & ~ev_up;
         c_nxt.pend_down = ev_up & ev_dn;
      end
      c_nxt.step = up_now | dn_now;
      if (COUNT_CLEAR) begin
         c_nxt.count = pcd_pkg::COUNT_RESET;
         c_nxt.pend_down = 1'b0;
         c_nxt.step = 1'b0;
      end else if (up_now || (dn_now && add_add_mode)) begin
         c_nxt.count = c_r.count + fac_ext;
      end else if (dn_now) begin
         c_nxt.count = c_r.count - fac_ext;
      end
   end
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         c_r.count <= pcd_pkg::COUNT_RESET;
         c_r.pend_down <= 1'b0;
         c_r.step <= 1'b0;
         c_r.user_b <= 1'b0;
         c_r.frac <= pcd_pkg::FRACTION_RESET;
         c_r.factor <= pcd_pkg::FACTOR_RESET;
      end else begin
         c_r <= c_nxt;
      end
   end
   assign COUNT_VALUE = c_r.count;
   assign FRACTION_DIGITS = c_r.frac;
   assign FACTOR_IN_USE = c_r.factor;
   assign SECOND_INPUT_USER_FUNCTION = c_r.user_b;
   assign USER_B_VALID = user_mode;
   assign COUNT_STEP = c_r.step;
   // ==========================================================================
   // Checks
   // The step just shown was scaled by the factor of the cycle before.
   logic signed [47:0] unity_ext;
   assign unity_ext = $signed({28'h000_0000, pcd_pkg::FACTOR_UNITY});
   a_unity_step: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      ($past(c_r.factor) == pcd_pkg::FACTOR_UNITY && c_r.step &&
       !$past(COUNT_CLEAR))
      |-> (c_r.count - $past(c_r.count) == unity_ext) ||
          ($past(c_r.count) - c_r.count == unity_ext))
      else $error("unity step not one unit");
   a_factor_range: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      ##1 (c_r.factor >= pcd_pkg::FACTOR_MIN &&
           c_r.factor <= pcd_pkg::FACTOR_MAX))
      else $error("factor out of range");
   a_factor_limit: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      $past(lim_one) |-> c_r.factor <= pcd_pkg::FACTOR_UNITY)
      else $error("factor above one while limited");
   a_fraction_max: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      c_r.frac <= pcd_pkg::FRACTION_MAX)
      else $error("fraction position above five");
   a_pend_drains: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      (c_r.pend_down && !COUNT_CLEAR) |=> c_r.step && !c_r.pend_down)
      else $error("parked count lost");
   a_addadd_up: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      (mode == pcd_pkg::add_add && $stable(mode) && c_r.step &&
       !$past(COUNT_CLEAR)) |-> c_r.count > $past(c_r.count))
      else $error("add add decremented");
   a_quad1_b_high: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      (mode == pcd_pkg::quad_x1 && b_lvl && !c_r.pend_down)
      |=> !c_r.step)
      else $error("quad x1 counted while b high");
   a_user_no_down: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      (user_mode && $past(user_mode) && c_r.step && !$past(COUNT_CLEAR))
      |-> c_r.count > $past(c_r.count))
      else $error("user mode counted down");
   c_coincide: cover property (@(posedge CLK_SYS) c_r.pend_down);
   c_quad4: cover property (@(posedge CLK_SYS)
      mode == pcd_pkg::quad_x4 && c_r.step);
   c_down: cover property (@(posedge CLK_SYS) c_r.step &&
      c_r.count < $past(c_r.count));
endmodule // pulse_count_input_decoder

// file: tb/pcd_pulse_source.sv
// Pulse source model for inputs A and B of the count decoder.
// Assumes the bench calls put from one sequential thread only.
`timescale 1ns/1ps
module pcd_pulse_source (
   input wire logic clk,
   output logic pin_a,
   output logic pin_b
);
   initial begin
      pin_a = 1'b1;
      pin_b = 1'b0;
   end
   // ==========================================================================
   // Level changes
   // Levels hold six cycles, above the three-cycle minimum, so that a
   // second event never lands in the drain cycle of a coincident pair.
   task automatic put(input logic a, input logic b);
      @(posedge clk);
      pin_a <= a;
      pin_b <= b;
      repeat (6) @(posedge clk);
   endtask
endmodule // pcd_pulse_source

// file: tb/pulse_count_input_decoder_bench.sv
// Self-checking bench: walks every count mode, factor clamps and fractions.
// Assumes the pulse source model and the decoder with its own assertions.
`timescale 1ns/1ps
module pulse_count_input_decoder_bench;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic in_a, in_b, user_b, user_ok, step, clr = 1'b0;
   logic sob = 1'b0;
   logic bat = 1'b0;
   logic [3:0] mode = 4'h0;
   logic [19:0] fac = pcd_pkg::FACTOR_UNITY;
   logic [19:0] eff = pcd_pkg::FACTOR_UNITY;
   logic [19:0] fiu;
   logic [2:0] pos = 3'h0;
   logic [2:0] frac;
   logic signed [47:0] cnt;
   longint exp_c = 0;
   int num_errors = 0;
   int check_count = 0;
   int steps = 0;
   int s0;
   pcd_pulse_source i_pcd_pulse_source (.clk(clk_sys), .pin_a(in_a),
      .pin_b(in_b));
   pulse_count_input_decoder i_pulse_count_input_decoder (.CLK_SYS(clk_sys),
      .RST_N(rst_n), .IN_A(in_a), .IN_B(in_b), .COUNT_MODE(mode),
      .SCALE_FACTOR(fac), .SCALED_OUTPUT_BUILD(sob), .BATCH_TOTALIZING(bat),
      .DISPLAY_FRACTION_POSITION(pos), .COUNT_CLEAR(clr), .COUNT_VALUE(cnt),
      .FRACTION_DIGITS(frac), .FACTOR_IN_USE(fiu),
      .SECOND_INPUT_USER_FUNCTION(user_b), .USER_B_VALID(user_ok),
      .COUNT_STEP(step));
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (step === 1'b1) steps <= steps + 1;
   // ==========================================================================
   // Tasks
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Moves the pins, then expects the count to have moved by d factors.
   task automatic mv(input logic a, input logic b, input int d);
      i_pcd_pulse_source.put(a, b);
      #1;
      exp_c = exp_c + d * longint'(eff);
      chk(cnt, exp_c[47:0]);
   endtask
   task automatic setm(input logic [3:0] m);
      @(posedge clk_sys);
      mode <= m;
      clr <= 1'b1;
      @(posedge clk_sys);
      clr <= 1'b0;
      #1;
      exp_c = 0;
      chk(cnt, 48'h0);
   endtask
   // Pins must stand at A high, B high on entry; leaves them at A high, B high.
   task automatic sf(input logic [19:0] f, input logic s, input logic b,
                     input logic [19:0] e);
      @(posedge clk_sys);
      fac <= f;
      sob <= s;
      bat <= b;
      eff = e;
      mv(1'b0, 1'b1, 1);
      chk({28'h0, fiu}, {28'h0, e});
      mv(1'b1, 1'b1, 0);
   endtask
   task automatic report_and_stop;
      $display("errors=%0d checks=%0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ==========================================================================
   // Main sequence
   initial begin
      #200us;
      num_errors++;
      report_and_stop;
   end
   initial begin
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      #1;
      chk(cnt, pcd_pkg::COUNT_RESET);
      chk({28'h0, fiu}, {28'h0, pcd_pkg::FACTOR_RESET});
      mv(1'b0, 1'b0, 1);
      chk({47'h0, user_b}, 48'h0);
      mv(1'b0, 1'b1, 0);
      chk({47'h0, user_b}, 48'h1);
      chk({47'h0, user_ok}, 48'h1);
      mv(1'b1, 1'b1, 0);
      setm(4'h1);
      mv(1'b0, 1'b1, 1);
      mv(1'b1, 1'b1, 1);
      setm(4'h2);
      chk({47'h0, user_ok}, 48'h0);
      mv(1'b0, 1'b1, 1);
      mv(1'b1, 1'b0, 0);
      mv(1'b0, 1'b0, -1);
      setm(4'h3);
      mv(1'b1, 1'b0, -1);
      mv(1'b1, 1'b1, 0);
      mv(1'b0, 1'b1, 1);
      mv(1'b0, 1'b0, 0);
      setm(4'h4);
      mv(1'b1, 1'b1, 0);
      mv(1'b0, 1'b1, 1);
      mv(1'b0, 1'b0, -1);
      mv(1'b1, 1'b1, 0);
      s0 = steps;
      mv(1'b0, 1'b0, 0);
      chk(48'(steps - s0), 48'h2);
      setm(4'h5);
      mv(1'b1, 1'b1, 0);
      s0 = steps;
      mv(1'b0, 1'b0, 2);
      chk(48'(steps - s0), 48'h2);
      setm(4'h6);
      mv(1'b1, 1'b0, -1);
      mv(1'b0, 1'b0, 1);
      mv(1'b0, 1'b1, 0);
      mv(1'b1, 1'b1, 0);
      mv(1'b0, 1'b1, 0);
      setm(4'h7);
      mv(1'b1, 1'b1, 1);
      mv(1'b0, 1'b1, -1);
      mv(1'b0, 1'b0, 0);
      mv(1'b1, 1'b0, -1);
      setm(4'h8);
      mv(1'b0, 1'b0, 1);
      mv(1'b0, 1'b1, 1);
      mv(1'b1, 1'b1, 1);
      mv(1'b1, 1'b0, 1);
      mv(1'b1, 1'b1, -1);
      mv(1'b0, 1'b1, -1);
      setm(4'h9);
      mv(1'b0, 1'b0, 0);
      setm(4'h0);
      mv(1'b1, 1'b1, 0);
      sf(20'h0_3039, 1'b0, 1'b0, 20'h0_3039);
      sf(20'h0_0000, 1'b0, 1'b0, pcd_pkg::FACTOR_MIN);
      sf(20'hF_FFFF, 1'b0, 1'b0, pcd_pkg::FACTOR_MAX);
      sf(20'h3_0D40, 1'b0, 1'b0, 20'h3_0D40);
      sf(20'h3_0D40, 1'b1, 1'b0, pcd_pkg::FACTOR_UNITY);
      sf(20'h3_0D40, 1'b0, 1'b1, pcd_pkg::FACTOR_UNITY);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_sys);
         pos <= 3'(i);
         repeat (2) @(posedge clk_sys);
         #1;
         chk({45'h0, frac}, {45'h0, (i > 5) ? 3'h5 : 3'(i)});
      end
      report_and_stop;
   end
endmodule // pulse_count_input_decoder_bench
